// File: core/qupf_pkg.sv
// Package for the quad UART pin-function select block: register map, reset values,
// field positions and the packed types that carry pad signals and the block state.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`default_nettype none
package qupf_pkg;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_OD = 8'h04;
  localparam logic [7:0] OFS_OUT = 8'h08;
  localparam logic [7:0] OFS_IN = 8'h0c;
  localparam logic [7:0] OFS_EVT_EN = 8'h10;
  localparam logic [7:0] OFS_INT_STS = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  localparam logic [7:0] OFS_CTS = 8'h1c;
  localparam logic [7:0] OFS_TIMER_CFG_HI = 8'h20;
  localparam logic [7:0] OFS_TX_SYNC_CTL = 8'h24;
  localparam logic [7:0] OFS_CLK_SRC_SEL = 8'h28;
  localparam logic [7:0] OFS_LINE_CTL0 = 8'h2c;
  localparam logic [7:0] OFS_LINE_CTL3 = 8'h38;

  // ==========================================================================
  // Field positions.
  localparam int TIMER_ROUTE_BIT = 7;
  localparam int REFCLK_ROUTE_BIT = 7;
  localparam int CLK_TO_RTS_BIT = 7;
  localparam int RTS_ASSERT_BIT = 1;
  localparam int CTS_EVT_LSB = 16;

  // Pins that carry the timer signal or the reference clock when routed.
  localparam logic [15:0] TIMER_PINS = 16'h2222;
  localparam logic [15:0] REFCLK_PINS = 16'h1111;

  // ==========================================================================
  // Reset values.
  localparam logic [15:0] RST_DIR = 16'h0000;
  localparam logic [15:0] RST_OD = 16'h0000;
  localparam logic [15:0] RST_OUT = 16'h0000;
  localparam logic [15:0] RST_EVT_EN = 16'h0000;
  localparam logic [19:0] RST_INT = 20'h00000;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [3:0] RST_SYNC_HI = 4'hf;
  localparam logic [15:0] RST_SYNC16 = 16'h0000;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic [15:0] o;
    logic [15:0] oe;
  } qupf_pad_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] dir;
    logic [15:0] od;
    logic [15:0] out;
    logic [15:0] evt_en;
    logic [19:0] ists;
    logic [19:0] imask;
    logic [7:0] tmr_cfg;
    logic [7:0] txs_ctl;
    logic [7:0] clk_src;
    logic [3:0][7:0] lc;
    logic [15:0] gpio_s1;
    logic [15:0] gpio_s2;
    logic [15:0] gpio_prev;
    logic [3:0] cts_s1;
    logic [3:0] cts_s2;
    logic [3:0] cts_prev;
    logic [3:0] rx_s1;
    logic [3:0] rx_s2;
    qupf_pad_t pad;
    logic [3:0] rts_n;
    logic [3:0] tx;
  } qupf_state_t;
endpackage : qupf_pkg
`default_nettype wire

// File: core/qupf_pin_select.sv
// Pin-function select for sixteen general-purpose pins and four UART pin groups.
// Assumes: pins arrive asynchronously; timer, reference clock, UART clocks and
// transmit data come from logic on clk; a classic Wishbone master drives the bus.
//
// Summary of operation
// RQ1: Each general pin is input, push-pull output, open-drain output or event source.
// RQ2: Timer route bit set puts the timer signal on pins 9 and 13.
// RQ3: Reference-clock route bit set puts the reference clock on pin 12.
// RQ4: Each request-to-send pin follows the level software sets in its line control.
// RQ5: Clock-to-RTS bit set puts the UART clock on request-to-send instead.
// RQ6: Request-to-send is active low; an asserted request drives the pin low.
// RQ7: The far side drives active-low clear-to-send, read here as send permission.
// RQ8: Each UART has its own receive input pin and transmit output pin.
// RQ9: Reference-clock route bit set also drives pins 0, 4 and 8.
// RQ10: Timer route bit set also drives pins 1 and 5.
// RQ11: With an override bit clear, pins return to their programmed function.
//
// Implementation choices: the address map and the Wishbone register port.
`default_nettype none
module qupf_pin_select (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic timer_sig,
  input wire logic ref_clk_sig,
  input wire logic [3:0] uart_clk_sig,
  input wire logic [3:0] uart_tx_int,
  output logic [3:0] uart_rx,
  output logic [3:0] uart_cts,
  input wire logic [15:0] gpio_i,
  output qupf_pkg::qupf_pad_t gpio_pad,
  output logic [3:0] rts_n_o,
  input wire logic [3:0] cts_n_i,
  input wire logic [3:0] rx_i,
  output logic [3:0] tx_o
);
  // ==========================================================================
  // State.
  qupf_pkg::qupf_state_t st;
  qupf_pkg::qupf_state_t next_st;
  logic wr_en;
  logic rd_en;
  logic sts_wr;

  // Byte-lane merge used by every writable register.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // ==========================================================================
  // Outputs straight from state; irq is a level while any unmasked event stands.
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign irq = |(st.ists & st.imask);
  assign uart_rx = st.rx_s2;
  assign uart_cts = ~st.cts_s2;
  assign gpio_pad = st.pad;
  assign rts_n_o = st.rts_n;
  assign tx_o = st.tx;

  // A request is served once; ack low in the cycle after it gives a clean gap.
  assign wr_en = wb_cyc_i && wb_stb_i && !st.ack && wb_we_i;
  assign rd_en = wb_cyc_i && wb_stb_i && !st.ack && !wb_we_i;
  assign sts_wr = wr_en && (wb_adr_i == qupf_pkg::OFS_INT_STS);

  // ==========================================================================
  // Next-state logic: bus slave, synchronisers, events and pin muxing.
  always_comb begin
    logic [15:0] edges;
    logic [19:0] set_ev;
    logic [19:0] clr_ev;
    logic [15:0] pad_o;
    logic [15:0] pad_oe;
    logic [31:0] rd;
    logic [31:0] mg;
    edges = '0;
    set_ev = '0;
    clr_ev = '0;
    pad_o = '0;
    pad_oe = '0;
    rd = '0;
    mg = '0;
    next_st = st;

    // Two flops on every pin input; the first stage is never looked at.
    next_st.gpio_s1 = gpio_i;
    next_st.gpio_s2 = st.gpio_s1;
    next_st.gpio_prev = st.gpio_s2;
    next_st.cts_s1 = cts_n_i; // RQ7
    next_st.cts_s2 = st.cts_s1;
    next_st.cts_prev = st.cts_s2;
    next_st.rx_s1 = rx_i; // RQ8
    next_st.rx_s2 = st.rx_s1;
    next_st.tx = uart_tx_int; // RQ8

    // Either edge on an input pin that is enabled as an event source.
    edges = (st.gpio_s2 ^ st.gpio_prev) & st.evt_en & ~st.dir; // RQ1
    set_ev = {st.cts_s2 ^ st.cts_prev, edges};

    // Register write; lanes beyond a register's width are ignored.
    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    if (wr_en) begin
      if (wb_adr_i == qupf_pkg::OFS_DIR) begin
        mg = lane_merge({16'h0000, st.dir}, wb_dat_i, wb_sel_i);
        next_st.dir = mg[15:0];
      end else if (wb_adr_i == qupf_pkg::OFS_OD) begin
        mg = lane_merge({16'h0000, st.od}, wb_dat_i, wb_sel_i);
        next_st.od = mg[15:0];
      end else if (wb_adr_i == qupf_pkg::OFS_OUT) begin
        mg = lane_merge({16'h0000, st.out}, wb_dat_i, wb_sel_i);
        next_st.out = mg[15:0];
      end else if (wb_adr_i == qupf_pkg::OFS_EVT_EN) begin
        mg = lane_merge({16'h0000, st.evt_en}, wb_dat_i, wb_sel_i);
        next_st.evt_en = mg[15:0];
      end else if (wb_adr_i == qupf_pkg::OFS_INT_STS) begin
        mg = lane_merge(32'h00000000, wb_dat_i, wb_sel_i);
        clr_ev = mg[19:0];
      end else if (wb_adr_i == qupf_pkg::OFS_INT_MASK) begin
        mg = lane_merge({12'h000, st.imask}, wb_dat_i, wb_sel_i);
        next_st.imask = mg[19:0];
      end else if (wb_adr_i == qupf_pkg::OFS_TIMER_CFG_HI) begin
        mg = lane_merge({24'h000000, st.tmr_cfg}, wb_dat_i, wb_sel_i);
        next_st.tmr_cfg = mg[7:0];
      end else if (wb_adr_i == qupf_pkg::OFS_TX_SYNC_CTL) begin
        mg = lane_merge({24'h000000, st.txs_ctl}, wb_dat_i, wb_sel_i);
        next_st.txs_ctl = mg[7:0];
      end else if (wb_adr_i == qupf_pkg::OFS_CLK_SRC_SEL) begin
        mg = lane_merge({24'h000000, st.clk_src}, wb_dat_i, wb_sel_i);
        next_st.clk_src = mg[7:0];
      end else if (wb_adr_i >= qupf_pkg::OFS_LINE_CTL0 && wb_adr_i <= qupf_pkg::OFS_LINE_CTL3
                   && wb_adr_i[1:0] == 2'b00) begin
        for (int u = 0; u < 4; u++) begin
          if (wb_adr_i == qupf_pkg::OFS_LINE_CTL0 + 8'(u * 4)) begin
            mg = lane_merge({24'h000000, st.lc[u]}, wb_dat_i, wb_sel_i);
            next_st.lc[u] = mg[7:0];
          end
        end
      end
    end

    // Sticky events: a new event wins over a clear in the same cycle.
    next_st.ists = (st.ists & ~clr_ev) | set_ev;

    // Register read; unmapped addresses answer with zero.
    if (wb_adr_i == qupf_pkg::OFS_DIR) begin
      rd = {16'h0000, st.dir};
    end else if (wb_adr_i == qupf_pkg::OFS_OD) begin
      rd = {16'h0000, st.od};
    end else if (wb_adr_i == qupf_pkg::OFS_OUT) begin
      rd = {16'h0000, st.out};
    end else if (wb_adr_i == qupf_pkg::OFS_IN) begin
      rd = {16'h0000, st.gpio_s2};
    end else if (wb_adr_i == qupf_pkg::OFS_EVT_EN) begin
      rd = {16'h0000, st.evt_en};
    end else if (wb_adr_i == qupf_pkg::OFS_INT_STS) begin
      rd = {12'h000, st.ists};
    end else if (wb_adr_i == qupf_pkg::OFS_INT_MASK) begin
      rd = {12'h000, st.imask};
    end else if (wb_adr_i == qupf_pkg::OFS_CTS) begin
      rd = {28'h0000000, ~st.cts_s2};
    end else if (wb_adr_i == qupf_pkg::OFS_TIMER_CFG_HI) begin
      rd = {24'h000000, st.tmr_cfg};
    end else if (wb_adr_i == qupf_pkg::OFS_TX_SYNC_CTL) begin
      rd = {24'h000000, st.txs_ctl};
    end else if (wb_adr_i == qupf_pkg::OFS_CLK_SRC_SEL) begin
      rd = {24'h000000, st.clk_src};
    end else if (wb_adr_i >= qupf_pkg::OFS_LINE_CTL0 && wb_adr_i <= qupf_pkg::OFS_LINE_CTL3
                 && wb_adr_i[1:0] == 2'b00) begin
      rd = {24'h000000, st.lc[wb_adr_i[3:2] - 2'd3]};
    end
    if (rd_en) begin
      next_st.rdata = rd;
    end

    // Programmed pin function: open drain only ever pulls low.
    for (int p = 0; p < 16; p++) begin
      if (st.dir[p] && st.od[p]) begin
        pad_o[p] = 1'b0; // RQ1
        pad_oe[p] = !st.out[p];
      end else begin
        pad_o[p] = st.out[p]; // RQ1
        pad_oe[p] = st.dir[p];
      end
    end
    // Routed signals are driven push-pull; with the bit clear the pin falls back.
    if (st.tmr_cfg[qupf_pkg::TIMER_ROUTE_BIT]) begin
      pad_o = (pad_o & ~qupf_pkg::TIMER_PINS) | ({16{timer_sig}} & qupf_pkg::TIMER_PINS); // RQ2 RQ10 RQ11
      pad_oe = pad_oe | qupf_pkg::TIMER_PINS; // RQ2 RQ10
    end
    if (st.txs_ctl[qupf_pkg::REFCLK_ROUTE_BIT]) begin
      pad_o = (pad_o & ~qupf_pkg::REFCLK_PINS) | ({16{ref_clk_sig}} & qupf_pkg::REFCLK_PINS); // RQ3 RQ9 RQ11
      pad_oe = pad_oe | qupf_pkg::REFCLK_PINS; // RQ3 RQ9
    end
    next_st.pad.o = pad_o;
    next_st.pad.oe = pad_oe;

    // Request-to-send: asserted request means a low pin, or the UART clock instead.
    for (int u = 0; u < 4; u++) begin
      if (st.clk_src[qupf_pkg::CLK_TO_RTS_BIT]) begin
        next_st.rts_n[u] = uart_clk_sig[u]; // RQ5
      end else begin
        next_st.rts_n[u] = !st.lc[u][qupf_pkg::RTS_ASSERT_BIT]; // RQ4 RQ6 RQ11
      end
    end
  end

  // ==========================================================================
  // State register; ce low freezes everything, including the bus handshake.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st.ack <= 1'b0;
      st.rdata <= 32'h00000000;
      st.dir <= qupf_pkg::RST_DIR;
      st.od <= qupf_pkg::RST_OD;
      st.out <= qupf_pkg::RST_OUT;
      st.evt_en <= qupf_pkg::RST_EVT_EN;
      st.ists <= qupf_pkg::RST_INT;
      st.imask <= qupf_pkg::RST_INT;
      st.tmr_cfg <= qupf_pkg::RST_CFG;
      st.txs_ctl <= qupf_pkg::RST_CFG;
      st.clk_src <= qupf_pkg::RST_CFG;
      st.lc <= {4{qupf_pkg::RST_CFG}};
      st.gpio_s1 <= qupf_pkg::RST_SYNC16;
      st.gpio_s2 <= qupf_pkg::RST_SYNC16;
      st.gpio_prev <= qupf_pkg::RST_SYNC16;
      st.cts_s1 <= qupf_pkg::RST_SYNC_HI;
      st.cts_s2 <= qupf_pkg::RST_SYNC_HI;
      st.cts_prev <= qupf_pkg::RST_SYNC_HI;
      st.rx_s1 <= qupf_pkg::RST_SYNC_HI;
      st.rx_s2 <= qupf_pkg::RST_SYNC_HI;
      st.pad <= '0;
      st.rts_n <= qupf_pkg::RST_SYNC_HI;
      st.tx <= qupf_pkg::RST_SYNC_HI;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Checks.
  a_rts_level: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
    ce && !st.clk_src[7] |=> rts_n_o[0] == !$past(st.lc[0][1]) && rts_n_o[3] == !$past(st.lc[3][1]))
    else $error("RTS pin does not follow line control level");

  a_rts_clock: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
    ce && st.clk_src[7] |=> rts_n_o == $past(uart_clk_sig))
    else $error("RTS pin does not carry the UART clock");

  a_rts_active_low: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
    ce && !st.clk_src[7] && st.lc[2][1] |=> !rts_n_o[2])
    else $error("Asserted request did not drive RTS low");

  a_timer_route: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
    ce && st.tmr_cfg[7] |=> gpio_pad.oe[9] && gpio_pad.oe[13]
    && gpio_pad.o[9] == $past(timer_sig) && gpio_pad.o[13] == $past(timer_sig))
    else $error("Timer signal missing on pins 9 and 13");

  a_timer_extra: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
    ce && st.tmr_cfg[7] |=> gpio_pad.oe[1] && gpio_pad.oe[5]
    && gpio_pad.o[1] == $past(timer_sig) && gpio_pad.o[5] == $past(timer_sig))
    else $error("Timer signal missing on pins 1 and 5");

  a_refclk_route: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
    ce && st.txs_ctl[7] |=> gpio_pad.oe[12] && gpio_pad.o[12] == $past(ref_clk_sig))
    else $error("Reference clock missing on pin 12");

  a_refclk_extra: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
    ce && st.txs_ctl[7] |=> gpio_pad.o[0] == $past(ref_clk_sig) && gpio_pad.o[4] == $past(ref_clk_sig)
    && gpio_pad.o[8] == $past(ref_clk_sig))
    else $error("Reference clock missing on pins 0, 4 or 8");

  a_route_release: assert property (@(posedge clk) disable iff (sys_rst) // RQ11
    ce && !st.txs_ctl[7] && !st.tmr_cfg[7] && !st.dir[12] |=> !gpio_pad.oe[12])
    else $error("Pin 12 still driven after override cleared");

  a_open_drain: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
    ce && st.dir[2] && st.od[2] |=> !gpio_pad.o[2] && gpio_pad.oe[2] == !$past(st.out[2]))
    else $error("Open-drain pin driven high");

  a_event_sticky: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
    ce && st.ists[2] && !sts_wr |=> st.ists[2])
    else $error("Event flag lost without a clear");

  a_rx_sync: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
    ce ##1 ce |=> uart_rx == $past(rx_i, 2))
    else $error("Receive pin not passed through two flops");

  a_tx_follow: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
    ce |=> tx_o == $past(uart_tx_int))
    else $error("Transmit pin does not follow UART data");

  a_ack_single: assert property (@(posedge clk) disable iff (sys_rst)
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 (!ce || !wb_ack_o))
    else $error("Bus ack not a single cycle answer");
endmodule : qupf_pin_select
`default_nettype wire

// File: test/qupf_board_model.sv
// Board-side model for the pin-function select block: pads, flow control, serial loop.
// Assumes the bench sets which pads it drives itself and the clear-to-send levels it wants.
`default_nettype none
module qupf_board_model (
  input wire qupf_pkg::qupf_pad_t gpio_pad,
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_val,
  input wire logic [3:0] cts_req_n,
  input wire logic [3:0] tx_o,
  output logic [15:0] gpio_i,
  output logic [3:0] cts_n_i,
  output logic [3:0] rx_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Pad resolution.
  // A released pad falls to its weak pull-down, so the last driven value never lingers.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      gpio_i[i] = gpio_pad.oe[i] ? gpio_pad.o[i] : (ext_en[i] ? ext_val[i] : 1'b0);
    end
  end
  // Flow-control status comes from the bench; transmit loops back to receive per UART.
  assign cts_n_i = cts_req_n;
  assign rx_i = tx_o;
endmodule : qupf_board_model
`default_nettype wire

// File: test/quad_uart_pin_function_select_tb.sv
// Self-checking bench for the pin-function select block over classic Wishbone.
// Assumes the board model resolves pads and loops each transmit pin to its receive pin.
`default_nettype none
module quad_uart_pin_function_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals.
  logic clk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, uart_clk_sig = 4'h0, uart_tx_int = 4'hf, cts_req_n = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, irq, timer_sig = 1'b0, ref_clk_sig = 1'b0, ce = 1'b1;
  logic [3:0] uart_rx, uart_cts, rts_n_o, cts_n_i, rx_i, tx_o;
  logic [15:0] gpio_i, ext_en = 16'h0, ext_val = 16'h0;
  qupf_pkg::qupf_pad_t gpio_pad;
  int miscompares = 0, total_checks = 0;
  always #5 clk = ~clk;
  // Design and board; the bench drives clock enable so that a freeze can be exercised.
  qupf_pin_select u_dut (.clk, .sys_rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .timer_sig, .ref_clk_sig, .uart_clk_sig,
    .uart_tx_int, .uart_rx, .uart_cts, .gpio_i, .gpio_pad, .rts_n_o, .cts_n_i, .rx_i, .tx_o);
  qupf_board_model u_board (.gpio_pad, .ext_en, .ext_val, .cts_req_n, .tx_o, .gpio_i, .cts_n_i, .rx_i);
  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; request held until ack is sampled high at a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rdc
  // Waits long enough for pad outputs and synchronisers to settle, off the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    check({rts_n_o, tx_o, uart_rx, uart_cts}, 16'hfff0);
    check(gpio_pad, 32'h0);
    check({31'h0, irq}, 32'h0);
    rdc(qupf_pkg::OFS_DIR, 32'h0);
    rdc(8'h3c, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_gpio;
    ext_en <= 16'h0004;
    ext_val <= 16'h0004;
    wr(qupf_pkg::OFS_DIR, 32'h3);
    wr(qupf_pkg::OFS_OD, 32'h2);
    wr(qupf_pkg::OFS_OUT, 32'h1);
    tick(3);
    check({gpio_pad.o, gpio_pad.oe}, 32'h0001_0003);
    rdc(qupf_pkg::OFS_IN, 32'h5);
    wr(qupf_pkg::OFS_OUT, 32'h3);
    tick(3);
    check({gpio_pad.o, gpio_pad.oe}, 32'h0001_0001);
    rdc(qupf_pkg::OFS_IN, 32'h5);
    wr(8'h3c, 32'hffff);
    rdc(qupf_pkg::OFS_DIR, 32'h3);
    $display("gpio test done");
  endtask : t_gpio
  task automatic t_route;
    wr(qupf_pkg::OFS_DIR, 32'h0);
    wr(qupf_pkg::OFS_OUT, 32'h0);
    timer_sig <= 1'b1;
    ref_clk_sig <= 1'b1;
    wr(qupf_pkg::OFS_TIMER_CFG_HI, 32'h80);
    tick(3);
    check({gpio_pad.o, gpio_pad.oe}, {2{qupf_pkg::TIMER_PINS}});
    wr(qupf_pkg::OFS_TX_SYNC_CTL, 32'h80);
    timer_sig <= 1'b0;
    tick(3);
    check({gpio_pad.o, gpio_pad.oe}, 32'h1111_3333);
    wr(qupf_pkg::OFS_TIMER_CFG_HI, 32'h0);
    wr(qupf_pkg::OFS_TX_SYNC_CTL, 32'h0);
    tick(3);
    check(gpio_pad.oe, 16'h0);
    $display("route test done");
  endtask : t_route
  task automatic t_rts;
    logic [3:0] exp;
    exp = 4'hf;
    for (int u = 0; u < 4; u++) begin
      wr(qupf_pkg::OFS_LINE_CTL0 + 8'(4 * u), 32'h2);
      exp[u] = 1'b0;
      tick(3);
      check(rts_n_o, exp);
    end
    wr(qupf_pkg::OFS_LINE_CTL0 + 8'h4, 32'h0);
    uart_clk_sig <= 4'ha;
    wr(qupf_pkg::OFS_CLK_SRC_SEL, 32'h80);
    tick(3);
    check(rts_n_o, 4'ha);
    uart_clk_sig <= 4'h5;
    tick(3);
    check(rts_n_o, 4'h5);
    wr(qupf_pkg::OFS_CLK_SRC_SEL, 32'h0);
    tick(3);
    check(rts_n_o, 4'h2);
    $display("rts test done");
  endtask : t_rts
  task automatic t_uart;
    uart_tx_int <= 4'h6;
    cts_req_n <= 4'h9;
    tick(5);
    check({tx_o, uart_rx, uart_cts}, 12'h666);
    rdc(qupf_pkg::OFS_CTS, 32'h6);
    rdc(qupf_pkg::OFS_INT_STS, 32'h60000);
    check(irq, 1'b0);
    wr(qupf_pkg::OFS_INT_MASK, 32'h20000);
    tick(1);
    check(irq, 1'b1);
    wr(qupf_pkg::OFS_INT_STS, 32'h20000);
    tick(1);
    check(irq, 1'b0);
    rdc(qupf_pkg::OFS_INT_STS, 32'h40000);
    wr(qupf_pkg::OFS_INT_STS, 32'h40000);
    $display("uart test done");
  endtask : t_uart
  task automatic t_event;
    ext_en <= 16'h000c;
    ext_val <= 16'h0004;
    wr(qupf_pkg::OFS_EVT_EN, 32'h4);
    wr(qupf_pkg::OFS_INT_MASK, 32'h4);
    ext_val <= 16'h0008;
    tick(6);
    check(irq, 1'b1);
    rdc(qupf_pkg::OFS_INT_STS, 32'h4);
    wr(qupf_pkg::OFS_INT_STS, 32'h4);
    tick(1);
    check(irq, 1'b0);
    $display("event test done");
  endtask : t_event
  // Clock enable low must hold the registered transmit output tx_o, then let it move again.
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    uart_tx_int <= 4'h9;
    tick(3);
    check(tx_o, 4'h6);
    @(posedge clk);
    ce <= 1'b1;
    tick(2);
    check(tx_o, 4'h9);
    $display("freeze test done");
  endtask : t_freeze
  // ==========================================================================
  // Verdict and run control.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // A hang would otherwise stall the run; the tests need well under a tenth of this span.
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    t_reset();
    t_gpio();
    t_route();
    t_rts();
    t_uart();
    t_event();
    t_freeze();
    complete_run();
  end
endmodule : quad_uart_pin_function_select_tb
`default_nettype wire
